// *** hdl/rsr_dev.sv ***
// Register slave end: serial port onto a 16-bit register file.
// Assumes the rsr_if link and a master clocking at standard speed.

////////////////////////////////////////////////////////////////////////////////
// Pin filter: three shift flops and an output flop, level changes once stages two and three agree
module rsr_filt (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Raw pin and filtered level
	input wire logic d_in,
	output logic q_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	// Idle level is high, as the lines are pulled up
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
			q_out <= 1'b1;
		end else begin
			s1_ff <= d_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				q_out <= s3_ff;
			end
		end
	end
endmodule : rsr_filt

////////////////////////////////////////////////////////////////////////////////
module rsr_dev import rsr_pkg::*; #(
	parameter int NREG = NREG_DEF,
	parameter int WDOG = WDOG_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Serial link
	rsr_if.device bus,
	// Address strap
	input wire logic slave_addr_select_pin_in,
	// Local read port
	input wire logic [15:0] loc_addr_in,
	output logic [15:0] loc_data_out,
	// Write notification
	output logic wr_pulse_out,
	output logic [15:0] wr_addr_out,
	output logic [15:0] wr_data_out,
	// Current pointer
	output logic [15:0] ptr_out
);
	localparam int AW = $clog2(NREG);
	localparam int WW = $clog2(WDOG + 1);

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TACK, ST_SKIP} rsr_dst_t;

	logic scl_f;              // Filtered clock line
	logic sda_f;              // Filtered data line
	logic sel_f;              // Filtered strap
	logic scl_q_ff;           // Clock level one cycle back
	logic sda_q_ff;           // Data level one cycle back
	rsr_dst_t state_ff;       // Protocol state
	logic [3:0] bitcnt_ff;    // Rising edges in current byte
	logic [2:0] idx_ff;       // Byte position in transaction
	logic [7:0] shreg_ff;     // Receive shifter
	logic rw_ff;              // Direction of this transaction
	logic [7:0] ahi_ff;       // Address high byte
	logic [7:0] alo_ff;       // Address low byte
	logic [7:0] dhi_ff;       // Data high byte
	logic [15:0] ptr_ff;      // Current address pointer
	logic [15:0] txd_ff;      // Transmit shifter
	logic txlo_ff;            // Low byte is being sent
	logic mack_ff;            // Master answer in read ack slot
	logic stretch_ff;         // Holding clock low
	logic [WW-1:0] wd_ff;     // Watchdog count
	logic sda_oe_ff;          // Pull data low
	logic lo_ff;              // Constant low drive level
	logic [15:0] regs_ff [NREG];

	////////////////////////////////////////////////////////////////////////////
	// Input filtering and edge detection
	rsr_filt u_scl (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(bus.scl_line), .q_out(scl_f));
	rsr_filt u_sda (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(bus.sda_line), .q_out(sda_f));
	rsr_filt u_sel (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(slave_addr_select_pin_in), .q_out(sel_f));

	wire scl_rise = scl_f && !scl_q_ff;
	wire scl_fall = !scl_f && scl_q_ff;
	// Data edges while clock stays high frame a transaction
	wire start_det = scl_f && scl_q_ff && sda_q_ff && !sda_f;
	wire stop_det = scl_f && scl_q_ff && !sda_q_ff && sda_f;
	wire byte_end = scl_fall && (bitcnt_ff == 4'h8);

	////////////////////////////////////////////////////////////////////////////
	// Decoding
	wire [6:0] own_addr = {SLV_ADDR_HI, sel_f};
	wire addr_match = (shreg_ff[7:1] == own_addr);
	wire [15:0] wr_addr = {ahi_ff, alo_ff};
	wire wr_mapped = (32'(wr_addr) < NREG);
	wire ptr_mapped = (32'(ptr_ff) < NREG);
	// Unmapped reads return zero once the watchdog lets go
	wire [15:0] ptr_word = ptr_mapped ? regs_ff[ptr_ff[AW-1:0]] : REG_RST;
	wire [15:0] wr_word = {dhi_ff, shreg_ff};
	wire reg_we = byte_end && (state_ff == ST_RX) && (idx_ff == IDX_DLO) && wr_mapped;

	// Line drive: open drain, only the enables move
	assign bus.d_scl_o = lo_ff;
	assign bus.d_sda_o = lo_ff;
	assign bus.d_scl_oe = stretch_ff;
	assign bus.d_sda_oe = sda_oe_ff;
	assign ptr_out = ptr_ff;

	////////////////////////////////////////////////////////////////////////////
	// Register file; reset loads REG_RST into every entry and into the read port flop
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < NREG; i++) begin
				regs_ff[i] <= REG_RST;
			end
			loc_data_out <= REG_RST;
		end else begin
			if (reg_we) begin
				regs_ff[wr_addr[AW-1:0]] <= wr_word;
			end
			loc_data_out <= (32'(loc_addr_in) < NREG) ? regs_ff[loc_addr_in[AW-1:0]] : REG_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write notification
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			wr_pulse_out <= 1'b0;
			wr_addr_out <= REG_RST;
			wr_data_out <= REG_RST;
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			lo_ff <= 1'b0;
		end else begin
			wr_pulse_out <= reg_we;
			if (reg_we) begin
				wr_addr_out <= wr_addr;
				wr_data_out <= wr_word;
			end
			scl_q_ff <= scl_f;
			sda_q_ff <= sda_f;
			lo_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Protocol engine; acts on filtered edges, and counts the watchdog down each cycle while stretching, slave side only
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_ff <= ST_IDLE;
			bitcnt_ff <= 4'h0;
			idx_ff <= IDX_CTRL;
			shreg_ff <= 8'h00;
			rw_ff <= 1'b0;
			ahi_ff <= 8'h00;
			alo_ff <= 8'h00;
			dhi_ff <= 8'h00;
			ptr_ff <= REG_RST;
			txd_ff <= REG_RST;
			txlo_ff <= 1'b0;
			mack_ff <= 1'b1;
			stretch_ff <= 1'b0;
			wd_ff <= '0;
			sda_oe_ff <= 1'b0;
		end else if (start_det) begin
			// Any Start reopens the port, also after a foreign address
			state_ff <= ST_RX;
			bitcnt_ff <= 4'h0;
			idx_ff <= IDX_CTRL;
			txlo_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (stop_det) begin
			state_ff <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_RX: begin
					if (scl_rise) begin
						shreg_ff <= {shreg_ff[6:0], sda_f};
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end else if (byte_end) begin
						bitcnt_ff <= 4'h0;
						idx_ff <= idx_ff + 3'h1;
						state_ff <= ST_ACK;
						sda_oe_ff <= 1'b1;
						if (idx_ff == IDX_CTRL) begin
							rw_ff <= shreg_ff[0];
							txd_ff <= ptr_word;
							if (!addr_match) begin
								// Foreign address: no acknowledge, stay quiet
								state_ff <= ST_SKIP;
								sda_oe_ff <= 1'b0;
							end else if (shreg_ff[0] && !ptr_mapped) begin
								stretch_ff <= 1'b1;
								wd_ff <= WW'(WDOG);
							end
						end else if (idx_ff == IDX_AHI) begin
							ahi_ff <= shreg_ff;
						end else if (idx_ff == IDX_ALO) begin
							alo_ff <= shreg_ff;
							ptr_ff <= {ahi_ff, shreg_ff};
						end else if (idx_ff == IDX_DHI) begin
							dhi_ff <= shreg_ff;
						end else if (idx_ff == IDX_DLO) begin
							// Only three kinds exist; a write ends here
							if (!wr_mapped) begin
								stretch_ff <= 1'b1;
								wd_ff <= WW'(WDOG);
							end
						end else begin
							// Bytes past a full write are refused
							state_ff <= ST_SKIP;
							sda_oe_ff <= 1'b0;
						end
					end
				end
				ST_ACK: begin
					if (stretch_ff) begin
						// Wait states until the watchdog runs out
						wd_ff <= wd_ff - WW'(1);
						if (wd_ff == '0) begin
							stretch_ff <= 1'b0;
						end
					end else if (scl_fall) begin
						bitcnt_ff <= 4'h0;
						if (rw_ff) begin
							state_ff <= ST_TX;
							sda_oe_ff <= !txd_ff[15];
							txd_ff <= {txd_ff[14:0], 1'b0};
						end else begin
							state_ff <= ST_RX;
							sda_oe_ff <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end else if (byte_end) begin
						// Release the line for the master's answer
						state_ff <= ST_TACK;
						sda_oe_ff <= 1'b0;
					end else if (scl_fall) begin
						sda_oe_ff <= !txd_ff[15];
						txd_ff <= {txd_ff[14:0], 1'b0};
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						mack_ff <= sda_f;
					end else if (scl_fall) begin
						bitcnt_ff <= 4'h0;
						if (!mack_ff && !txlo_ff) begin
							// High byte acknowledged: low byte follows
							txlo_ff <= 1'b1;
							state_ff <= ST_TX;
							sda_oe_ff <= !txd_ff[15];
							txd_ff <= {txd_ff[14:0], 1'b0};
						end else begin
							state_ff <= ST_SKIP;
						end
					end
				end
				default: begin
					// Idle or skipping: line released
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end
endmodule : rsr_dev

// *** hdl/rsr_if.sv ***
// Two-wire link between the register master and the register slave.
// Both lines are open drain with pull-ups; the level is resolved here.
interface rsr_if;
	// Master drive
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	// Device drive
	logic d_scl_o;
	logic d_scl_oe;
	logic d_sda_o;
	logic d_sda_oe;
	// Resolved wired-AND levels
	logic scl_line;
	logic sda_line;
	assign scl_line = !((m_scl_oe && !m_scl_o) || (d_scl_oe && !d_scl_o));
	assign sda_line = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
	modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl_line, sda_line);
	modport device (output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, input scl_line, sda_line);
endinterface : rsr_if

// *** hdl/rsr_mst.sv ***
// Register master end: command queue feeding a two-wire bus master.
// Assumes one rsr_dev on the link and a 100 MHz clock.

////////////////////////////////////////////////////////////////////////////////
// Command queue; depth must be a power of two
module rsr_fifo #(
	parameter int W = 34,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ff;
	logic [PW-1:0] rd_ff;
	logic [PW:0] cnt_ff;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	wire [PW:0] nxt_cnt = cnt_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	assign out_data_out = mem_ff[rd_ff];

	// Flags are registered from the next count, so they are honest each cycle
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			in_ready_out <= (nxt_cnt != (PW + 1)'(DEPTH));
			out_valid_out <= (nxt_cnt != '0);
			wr_ff <= wr_ff + PW'(push);
			rd_ff <= rd_ff + PW'(pop);
		end
	end

	// Storage carries no reset
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_in;
		end
	end
endmodule : rsr_fifo

////////////////////////////////////////////////////////////////////////////////
// Bus master: each bit is four quarter periods of the serial clock
module rsr_mst import rsr_pkg::*; #(
	parameter int QTR = SCL_QTR_CYC,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Serial link
	rsr_if.master bus,
	// Command port
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire rsr_op_t cmd_op_in,
	input wire logic [15:0] cmd_addr_in,
	input wire logic [15:0] cmd_data_in,
	input wire logic tgt_sel_in,
	// Results
	output logic rd_valid_out,
	output logic [15:0] rd_data_out,
	output logic nack_out,
	output logic busy_out
);
	localparam int QW = $clog2(QTR + 1);
	typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} rsr_mst_t;

	rsr_mst_t state_ff;
	logic [QW-1:0] qcnt_ff;   // Quarter period timer
	logic [1:0] ph_ff;        // Quarter within bit
	logic [3:0] bit_ff;       // Bit in byte, 8 is the ack slot
	logic [2:0] idx_ff;       // Byte in transaction
	logic [2:0] nb_ff;        // Bytes in transaction
	logic rdm_ff;             // Read transaction
	logic pend_ff;            // Read follows pointer load
	rsr_op_t op_ff;
	logic [15:0] addr_ff;
	logic [15:0] data_ff;
	logic [7:0] shreg_ff;
	logic [7:0] rdh_ff;
	logic scl_oe_ff;
	logic sda_oe_ff;
	logic lo_ff;
	logic scl_f;
	logic sda_f;
	logic q_valid;
	logic [CMD_W-1:0] q_data;

	rsr_filt u_scl (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(bus.scl_line), .q_out(scl_f));
	rsr_filt u_sda (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(bus.sda_line), .q_out(sda_f));

	// Queue stalls while a transaction runs, so back-pressure reaches the user
	wire q_pop = q_valid && (state_ff == M_IDLE);
	rsr_fifo #(.W(CMD_W), .DEPTH(DEPTH)) u_q (
		.clk_in(clk_in), .nrst_in(nrst_in),
		.in_valid_in(cmd_valid_in), .in_ready_out(cmd_ready_out),
		.in_data_in({cmd_op_in, cmd_addr_in, cmd_data_in}),
		.out_valid_out(q_valid), .out_ready_in(q_pop), .out_data_out(q_data)
	);

	// A released clock that reads low is being stretched: hold the timer
	wire hold = !scl_oe_ff && !scl_f && (state_ff != M_IDLE) && (ph_ff != 2'h1);
	wire tick = (qcnt_ff == '0) && !hold;
	wire rx_byte = rdm_ff && (idx_ff != IDX_CTRL);
	wire last_byte = (idx_ff == nb_ff - 3'h1);
	wire [7:0] tx_byte = (idx_ff == IDX_CTRL) ? {SLV_ADDR_HI, tgt_sel_in, rdm_ff} :
		(idx_ff == IDX_AHI) ? addr_ff[15:8] :
		(idx_ff == IDX_ALO) ? addr_ff[7:0] :
		(idx_ff == IDX_DHI) ? data_ff[15:8] : data_ff[7:0];
	wire ack_bad = (bit_ff == 4'h8) && !rx_byte && sda_f;

	assign bus.m_scl_o = lo_ff;
	assign bus.m_sda_o = lo_ff;
	assign bus.m_scl_oe = scl_oe_ff;
	assign bus.m_sda_oe = sda_oe_ff;

	////////////////////////////////////////////////////////////////////////////
	// Quarter timer at standard speed
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			qcnt_ff <= QW'(QTR - 1);
			lo_ff <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			lo_ff <= 1'b0;
			busy_out <= (state_ff != M_IDLE);
			if (state_ff == M_IDLE || tick) begin
				qcnt_ff <= QW'(QTR - 1);
			end else if (!hold) begin
				qcnt_ff <= qcnt_ff - QW'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_ff <= M_IDLE;
			ph_ff <= 2'h0;
			bit_ff <= 4'h0;
			idx_ff <= IDX_CTRL;
			nb_ff <= NB_PTR;
			rdm_ff <= 1'b0;
			pend_ff <= 1'b0;
			op_ff <= RSR_OP_SETPTR;
			addr_ff <= 16'h0000;
			data_ff <= 16'h0000;
			shreg_ff <= 8'h00;
			rdh_ff <= 8'h00;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			rd_valid_out <= 1'b0;
			rd_data_out <= 16'h0000;
			nack_out <= 1'b0;
		end else begin
			rd_valid_out <= 1'b0;
			if (state_ff == M_IDLE) begin
				if (q_valid) begin
					op_ff <= rsr_op_t'(q_data[33:32]);
					addr_ff <= q_data[31:16];
					data_ff <= q_data[15:0];
					rdm_ff <= 1'b0;
					// A read first loads the pointer
					nb_ff <= (rsr_op_t'(q_data[33:32]) == RSR_OP_WRITE) ? NB_WR : NB_PTR;
					pend_ff <= (rsr_op_t'(q_data[33:32]) == RSR_OP_READ);
					nack_out <= 1'b0;
					idx_ff <= IDX_CTRL;
					bit_ff <= 4'h0;
					ph_ff <= 2'h0;
					state_ff <= M_START;
				end
			end else if (tick) begin
				ph_ff <= ph_ff + 2'h1;
				case (state_ff)
					M_START: begin
						// Data falls while clock is high, then clock goes low
						if (ph_ff == 2'h0) begin
							sda_oe_ff <= 1'b1;
						end else begin
							scl_oe_ff <= 1'b1;
							ph_ff <= 2'h0;
							state_ff <= M_BIT;
						end
					end
					M_BIT: begin
						if (ph_ff == 2'h0) begin
							if (bit_ff != 4'h8) begin
								sda_oe_ff <= rx_byte ? 1'b0 : !tx_byte[~bit_ff[2:0]];
							end else begin
								sda_oe_ff <= rx_byte && !last_byte;
							end
						end else if (ph_ff == 2'h1) begin
							scl_oe_ff <= 1'b0;
						end else if (ph_ff == 2'h2) begin
							if (bit_ff != 4'h8) begin
								shreg_ff <= {shreg_ff[6:0], sda_f};
							end else if (ack_bad) begin
								nack_out <= 1'b1;
							end
						end else begin
							scl_oe_ff <= 1'b1;
							bit_ff <= bit_ff + 4'h1;
							if (bit_ff == 4'h8) begin
								bit_ff <= 4'h0;
								idx_ff <= idx_ff + 3'h1;
								if (rx_byte && !last_byte) begin
									rdh_ff <= shreg_ff;
								end
								if (rx_byte && last_byte) begin
									rd_data_out <= {rdh_ff, shreg_ff};
									rd_valid_out <= 1'b1;
								end
								if (last_byte || nack_out) begin
									state_ff <= M_STOP;
								end
							end
						end
					end
					M_STOP: begin
						// Data low, clock up, then data rises while clock is high
						if (ph_ff == 2'h0) begin
							sda_oe_ff <= 1'b1;
						end else if (ph_ff == 2'h1) begin
							scl_oe_ff <= 1'b0;
						end else if (ph_ff == 2'h2) begin
							sda_oe_ff <= 1'b0;
						end else if (pend_ff && !nack_out) begin
							pend_ff <= 1'b0;
							rdm_ff <= 1'b1;
							nb_ff <= NB_PTR;
							idx_ff <= IDX_CTRL;
							state_ff <= M_START;
						end else begin
							state_ff <= M_IDLE;
						end
					end
					default: begin
						state_ff <= M_IDLE;
					end
				endcase
			end
		end
	end
endmodule : rsr_mst

// *** hdl/rsr_pkg.sv ***
// Constants shared by both ends of the register access serial link.
// Assumes a 100 MHz system clock on each end.
package rsr_pkg;
	// Fixed upper six bits of the 7-bit slave address
	localparam logic [5:0] SLV_ADDR_HI = 6'h38;
	// Timing base
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_FREQ_KHZ = 100;
	// Quarter of the serial clock period, rounded down
	localparam int SCL_QTR_CYC = (1000000 / SCL_FREQ_KHZ) / CLK_PERIOD_NS / 4;
	// Watchdog that ends clock stretching on unmapped addresses
	localparam int WDOG_US = 1000;
	localparam int WDOG_CYC = (WDOG_US * 1000) / CLK_PERIOD_NS;
	// Register file size and reset value
	localparam int NREG_DEF = 256;
	localparam logic [15:0] REG_RST = 16'h0000;
	// Byte positions inside a transaction
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_AHI = 3'h1;
	localparam logic [2:0] IDX_ALO = 3'h2;
	localparam logic [2:0] IDX_DHI = 3'h3;
	localparam logic [2:0] IDX_DLO = 3'h4;
	// Byte counts per transaction kind
	localparam logic [2:0] NB_PTR = 3'h3;
	localparam logic [2:0] NB_WR = 3'h5;
	// Command queue in the master
	localparam int FIFO_DEPTH = 32;
	localparam int CMD_W = 34;
	// Transaction kinds
	typedef enum logic [1:0] {RSR_OP_SETPTR, RSR_OP_WRITE, RSR_OP_READ} rsr_op_t;
endpackage : rsr_pkg

// *** sim/rsr_chk_sva.sv ***
// Checker for the two-wire link between the master end and the device end.
// Assumes it is instantiated beside the interface and sees its signals as inputs.
module rsr_chk #(
	parameter int WDOG = 200
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Drive controls of both ends
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic d_scl_oe,
	// Resolved line levels
	input wire logic scl_line,
	input wire logic sda_line
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////////////////////////////////////////////
	// Length of the current stretch; a hung device would let it grow without end
	logic [31:0] str_ff;
	logic [31:0] nxt_str;
	assign nxt_str = d_scl_oe ? str_ff + 32'h0000_0001 : 32'h0000_0000;
	always_ff @(posedge clk_in) begin
		str_ff <= nrst_in ? nxt_str : 32'h0000_0000;
	end
	////////////////////////////////////////////////////////////////////////////////
	AST_OPEN_DRAIN: assert property (!m_sda_o && !d_sda_o)
		else $error("data line driven to a high level");
	AST_DEV_SDA_LOW: assert property ($changed(d_sda_oe) |-> !scl_line)
		else $error("device changed data while clock high");
	AST_STRETCH_LOW: assert property ($rose(d_scl_oe) |-> !scl_line)
		else $error("device pulled clock while it was high");
	AST_STRETCH_MAX: assert property (str_ff <= WDOG + 8)
		else $error("clock stretch outlived the watchdog");
	AST_SCL_HIGH: assert property ($rose(scl_line) |-> scl_line [*8])
		else $error("clock high phase too short");
	AST_START_CLK: assert property ($rose(m_sda_oe) && scl_line |-> ##[1:60] !scl_line)
		else $error("no clock after start");
	AST_STOP_IDLE: assert property ($fell(m_sda_oe) && scl_line |-> sda_line [*8])
		else $error("data line not free after stop");
	AST_NO_CLASH: assert property (scl_line |-> !(m_sda_oe && d_sda_oe))
		else $error("both ends drive data while clock high");
	// Main scenarios seen
	cover property ($rose(d_scl_oe));
	cover property ($fell(m_sda_oe) && scl_line);
	cover property ($rose(d_sda_oe) && scl_line == 1'b0);
endmodule : rsr_chk

// *** sim/tb.sv ***
// Testbench joining the master end and the device end over one link.
// Assumes shortened quarter period and watchdog so the run stays short.
module tb import rsr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WD = 200;
	// Design inputs, all set at time zero
	logic clk_in = 1'b0, nrst_in = 1'b0, cmd_valid = 1'b0, tgt = 1'b0, pin = 1'b0;
	rsr_op_t cmd_op = RSR_OP_SETPTR;
	logic [15:0] cmd_addr = 16'h0000, cmd_data = 16'h0000, loc_addr = 16'h0000;
	// Design outputs
	logic cmd_ready, rd_valid, nack, busy, wr_pulse;
	logic [15:0] rd_data, loc_data, wr_addr, wr_data, ptr;
	int miscompares = 0, compares = 0, n_wr = 0, n_rd = 0;
	logic saw_str = 1'b0;
	always #5 clk_in = ~clk_in;
	rsr_if rsr_if_inst ();
	rsr_dev #(.WDOG(WD)) rsr_dev_inst (.clk_in(clk_in), .nrst_in(nrst_in), .bus(rsr_if_inst.device),
		.slave_addr_select_pin_in(pin), .loc_addr_in(loc_addr), .loc_data_out(loc_data),
		.wr_pulse_out(wr_pulse), .wr_addr_out(wr_addr), .wr_data_out(wr_data), .ptr_out(ptr));
	rsr_mst #(.QTR(10)) rsr_mst_inst (.clk_in(clk_in), .nrst_in(nrst_in), .bus(rsr_if_inst.master),
		.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
		.cmd_data_in(cmd_data), .tgt_sel_in(tgt), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
		.nack_out(nack), .busy_out(busy));
	rsr_chk #(.WDOG(WD)) rsr_chk_inst (.clk_in(clk_in), .nrst_in(nrst_in), .m_sda_o(rsr_if_inst.m_sda_o),
		.m_sda_oe(rsr_if_inst.m_sda_oe), .d_sda_o(rsr_if_inst.d_sda_o), .d_sda_oe(rsr_if_inst.d_sda_oe),
		.d_scl_oe(rsr_if_inst.d_scl_oe), .scl_line(rsr_if_inst.scl_line), .sda_line(rsr_if_inst.sda_line));
	////////////////////////////////////////////////////////////////////////////////
	// Pulse counters, sampled away from the launching edge
	always @(negedge clk_in) begin
		if (wr_pulse === 1'b1) n_wr++;
		if (rd_valid === 1'b1) n_rd++;
		if (rsr_if_inst.d_scl_oe === 1'b1) saw_str = 1'b1;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Offer one command, then wait until the master has been idle a while
	task automatic run(input rsr_op_t op, input logic [15:0] a, input logic [15:0] d);
		int q;
		@(negedge clk_in);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		// Ready is a flop: its level at this falling edge decides the next rising edge
		while (cmd_ready !== 1'b1) @(negedge clk_in);
		@(negedge clk_in);
		cmd_valid = 1'b0;
		q = 0;
		while (q < 50) begin
			@(negedge clk_in);
			q = (busy === 1'b0) ? q + 1 : 0;
		end
	endtask : run
	task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic ok);
		int nw;
		nw = n_wr;
		run(RSR_OP_WRITE, a, d);
		chk("write pulses", 16'(nw + int'(ok)), 16'(n_wr));
		if (ok) begin
			chk("write addr", a, wr_addr);
			chk("write data", d, wr_data);
			chk("pointer", a, ptr);
		end
	endtask : wr_chk
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		int nr;
		nr = n_rd;
		run(RSR_OP_READ, a, 16'h0000);
		chk("read pulses", 16'(nr + 1), 16'(n_rd));
		chk("read data", exp, rd_data);
		chk("nack", 16'h0000, {15'h0000, nack});
	endtask : rd_chk
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_write_read();
		wr_chk(16'h0012, 16'hA55A, 1'b1);
		wr_chk(16'h00FF, 16'h8001, 1'b1);
		rd_chk(16'h0012, 16'hA55A);
		rd_chk(16'h00FF, 16'h8001);
		loc_addr = 16'h00FF;
		repeat (2) @(negedge clk_in);
		chk("local read", 16'h8001, loc_data);
	endtask : t_write_read
	task automatic t_pointer();
		int nw;
		nw = n_wr;
		run(RSR_OP_SETPTR, 16'h0034, 16'hFFFF);
		chk("pointer", 16'h0034, ptr);
		chk("write pulses", 16'(nw), 16'(n_wr));
	endtask : t_pointer
	task automatic t_foreign();
		tgt = 1'b1;
		wr_chk(16'h0012, 16'h0BAD, 1'b0);
		chk("nack", 16'h0001, {15'h0000, nack});
		chk("pointer", 16'h0034, ptr);
		pin = 1'b1;
		wr_chk(16'h0013, 16'h1357, 1'b1);
		tgt = 1'b0;
		pin = 1'b0;
		rd_chk(16'h0012, 16'hA55A);
	endtask : t_foreign
	task automatic t_unmapped();
		wr_chk(16'h0100, 16'h7777, 1'b0);
		chk("pointer", 16'h0100, ptr);
		chk("stretch", 16'h0001, {15'h0000, saw_str});
		rd_chk(16'h0100, 16'h0000);
	endtask : t_unmapped
	// Queue filled until refused, then drained; order shows in the final pointer
	task automatic t_fill();
		int acc;
		acc = 0;
		@(negedge clk_in);
		cmd_valid = 1'b1;
		cmd_op = RSR_OP_SETPTR;
		// Ready seen high at a falling edge means the next rising edge takes the command
		while (acc < 40) begin
			cmd_addr = 16'h0040 + 16'(acc);
			if (cmd_ready !== 1'b1) break;
			@(negedge clk_in);
			acc++;
		end
		cmd_valid = 1'b0;
		// A full queue plus the one command the idle master has already taken
		chk("accepted", 16'(FIFO_DEPTH + 1), 16'(acc));
		run(RSR_OP_SETPTR, 16'h0021, 16'h0000);
		chk("pointer", 16'h0021, ptr);
	endtask : t_fill
	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// Watchdog: the tests need about 60000 cycles
	initial begin
		repeat (90000) @(posedge clk_in);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		nrst_in = 1'b1;
		repeat (4) @(negedge clk_in);
		t_write_read();
		t_pointer();
		t_foreign();
		t_unmapped();
		t_fill();
		tally_and_finish();
	end
endmodule : tb
